// [src/data_space_map.sv]
// Function
// - Program counter is 12 bits wide, reaching 4K bytes of program memory.
// - With readout protection set, an external program memory read is refused unless a request is already in flight.
// - Protection clears only together with a full program memory erase or a reset.
// - Constants come from program memory through a 64-byte data space window.
// - Decoder maps RAM, accumulator, index, short direct, port, peripheral registers.
// - Return stack has six 12-bit entries for return addresses.
// - Index and short direct registers at 080h-083h, read/write, undefined reset.
// - Port A/B data registers at 0C0h/0C1h, read/write, reset to zero.
// - Port A/B direction registers at 0C4h/0C5h, read/write, reset to zero.
// - Interrupt options 0C8h and window select 0C9h are write-only, undefined reset.
// - Port A/B option registers at 0CCh/0CDh, read/write, reset to zero.
// - Converter result at 0D0h is read-only, undefined after reset.
// - Converter control at 0D1h mixes read-only and write-only bits, resets 40h.
// - Timer prescaler at 0D2h is read/write, resets to 7Fh.
// - Timer downcounter at 0D3h is read/write, resets to 0FFh.
// - Timer status and control at 0D4h is read/write, resets to zero.
// - Window at 0040h-007Fh returns program byte at selected block plus offset.
// - Port data reads give latch for outputs, filtered pin level for inputs.
module data_space_map (
  // Clock and reset
  input  wire logic                                   clock,
  input  wire logic                                   rst_b,
  // Core data access
  input  wire logic [data_space_pkg::ADDR_W-1:0]      data_addr,
  input  wire logic                                   data_rd,
  input  wire logic                                   data_wr,
  input  wire logic [data_space_pkg::DATA_W-1:0]      data_wdata,
  output logic      [data_space_pkg::DATA_W-1:0]      data_rdata,
  output logic                                        data_rvalid,
  // Program counter and return stack
  input  wire data_space_pkg::pc_op_t                 pc_op,
  input  wire logic [data_space_pkg::PC_W-1:0]        pc_target,
  output logic      [data_space_pkg::PC_W-1:0]        program_counter,
  // Program memory read port for the data window
  output logic      [data_space_pkg::PC_W-1:0]        window_rom_addr,
  input  wire logic [data_space_pkg::DATA_W-1:0]      window_rom_data,
  // External program memory readout
  input  wire logic                                   ext_rd,
  input  wire logic [data_space_pkg::PC_W-1:0]        ext_addr,
  output logic      [data_space_pkg::PC_W-1:0]        ext_rom_addr,
  input  wire logic [data_space_pkg::DATA_W-1:0]      ext_rom_data,
  output logic      [data_space_pkg::DATA_W-1:0]      ext_rdata,
  output logic                                        ext_rvalid,
  output logic                                        ext_refused,
  // Protection option and erase
  input  wire logic                                   protect_option,
  input  wire logic                                   erase_all,
  output logic                                        protect_active,
  // Port pins
  input  wire logic [data_space_pkg::PORT_W-1:0]      port_a_in,
  output logic      [data_space_pkg::PORT_W-1:0]      port_a_out,
  output logic      [data_space_pkg::PORT_W-1:0]      port_a_oe,
  output logic      [data_space_pkg::PORT_W-1:0]      port_a_pin_options,
  input  wire logic [data_space_pkg::PORT_W-1:0]      port_b_in,
  output logic      [data_space_pkg::PORT_W-1:0]      port_b_out,
  output logic      [data_space_pkg::PORT_W-1:0]      port_b_oe,
  output logic      [data_space_pkg::PORT_W-1:0]      port_b_pin_options,
  // Peripheral register images
  input  wire logic [data_space_pkg::DATA_W-1:0]      converter_result_in,
  input  wire logic [data_space_pkg::DATA_W-1:0]      converter_status_in,
  output logic      [data_space_pkg::DATA_W-1:0]      converter_control,
  output logic      [data_space_pkg::DATA_W-1:0]      timer_prescaler,
  output logic      [data_space_pkg::DATA_W-1:0]      timer_downcounter,
  output logic      [data_space_pkg::DATA_W-1:0]      timer_status_control,
  output logic      [data_space_pkg::DATA_W-1:0]      watchdog_counter,
  output logic      [data_space_pkg::DATA_W-1:0]      interrupt_options
);
  import data_space_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [RAM_WORDS-1:0][DATA_W-1:0] ram;
    logic [DATA_W-1:0]                index_one;
    logic [DATA_W-1:0]                index_two;
    logic [DATA_W-1:0]                short_one;
    logic [DATA_W-1:0]                short_two;
    logic [DATA_W-1:0]                accumulator;
    logic [DATA_W-1:0]                int_options;
    logic [WIN_SEL_W-1:0]             win_select;
    logic [DATA_W-1:0]                conv_ctrl;
    logic [DATA_W-1:0]                prescaler;
    logic [DATA_W-1:0]                downcounter;
    logic [DATA_W-1:0]                timer_sc;
    logic [DATA_W-1:0]                watchdog;
    rd_state_t                        rd_state;
    logic [ADDR_W-1:0]                rd_addr;
    logic [DATA_W-1:0]                rdata;
    logic                             rvalid;
    logic [PC_W-1:0]                  pc;
    logic [PC_W-1:0]                  win_addr;
    logic                             protect;
    logic                             ext_pending;
    logic [PC_W-1:0]                  ext_addr;
    logic [DATA_W-1:0]                ext_data;
    logic                             ext_valid;
    logic                             ext_refuse;
  } map_state_t;

  map_state_t s;
  map_state_t next_s;

  logic [1:0]        rst_sync;
  logic              rst_n;
  logic              wr_a_data;
  logic              wr_b_data;
  logic              wr_a_dir;
  logic              wr_b_dir;
  logic              wr_a_opt;
  logic              wr_b_opt;
  logic [PORT_W-1:0] a_data_view;
  logic [PORT_W-1:0] a_dir_view;
  logic [PORT_W-1:0] b_data_view;
  logic [PORT_W-1:0] b_dir_view;
  logic              stack_push;
  logic              stack_pop;
  logic [PC_W-1:0]   stack_top;
  logic [PC_W-1:0]   pc_next_seq;
  logic [DATA_W-1:0] read_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Port and stack blocks

  assign wr_a_data = data_wr && (data_addr == PORT_A_PIN_DATA);
  assign wr_b_data = data_wr && (data_addr == PORT_B_PIN_DATA);
  assign wr_a_dir  = data_wr && (data_addr == PORT_A_DIRECTION);
  assign wr_b_dir  = data_wr && (data_addr == PORT_B_DIRECTION);
  assign wr_a_opt  = data_wr && (data_addr == PORT_A_PIN_OPTIONS);
  assign wr_b_opt  = data_wr && (data_addr == PORT_B_PIN_OPTIONS);

  io_port_regs #(.W(PORT_W)) port_a (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_data   (wr_a_data),
    .wr_dir    (wr_a_dir),
    .wr_opt    (wr_a_opt),
    .wdata     (data_wdata),
    .pin_in    (port_a_in),
    .pin_out   (port_a_out),
    .pin_oe    (port_a_oe),
    .options   (port_a_pin_options),
    .data_view (a_data_view),
    .dir_view  (a_dir_view)
  );

  io_port_regs #(.W(PORT_W)) port_b (
    .clock     (clock),
    .rst_n     (rst_n),
    .wr_data   (wr_b_data),
    .wr_dir    (wr_b_dir),
    .wr_opt    (wr_b_opt),
    .wdata     (data_wdata),
    .pin_in    (port_b_in),
    .pin_out   (port_b_out),
    .pin_oe    (port_b_oe),
    .options   (port_b_pin_options),
    .data_view (b_data_view),
    .dir_view  (b_dir_view)
  );

  assign stack_push  = (pc_op == PC_CALL);
  assign stack_pop   = (pc_op == PC_RETURN);
  assign pc_next_seq = s.pc + 12'h001;

  return_stack #(.DEPTH(STACK_DEPTH), .W(PC_W)) stack (
    .clock      (clock),
    .rst_n      (rst_n),
    .push       (stack_push),
    .pop        (stack_pop),
    .push_value (pc_next_seq),
    .top        (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read decode, evaluated in the lookup cycle

  always_comb begin
    read_mux = UNMAPPED_READ;
    if (s.rd_addr <= RAM_LAST) begin
      read_mux = s.ram[s.rd_addr[WIN_OFS_W-1:0]];
    end else if (s.rd_addr <= WINDOW_LAST) begin
      read_mux = window_rom_data;
    end else begin
      case (s.rd_addr)
        INDEX_POINTER_ONE:    read_mux = s.index_one;
        INDEX_POINTER_TWO:    read_mux = s.index_two;
        SHORT_DIRECT_ONE:     read_mux = s.short_one;
        SHORT_DIRECT_TWO:     read_mux = s.short_two;
        PORT_A_PIN_DATA:      read_mux = a_data_view;
        PORT_B_PIN_DATA:      read_mux = b_data_view;
        PORT_A_DIRECTION:     read_mux = a_dir_view;
        PORT_B_DIRECTION:     read_mux = b_dir_view;
        PORT_A_PIN_OPTIONS:   read_mux = port_a_pin_options;
        PORT_B_PIN_OPTIONS:   read_mux = port_b_pin_options;
        CONVERTER_RESULT:     read_mux = converter_result_in;
        CONVERTER_CONTROL: begin
          // Write-only bits read back as zero
          read_mux = converter_status_in & CONV_CTRL_RO_MASK;
        end
        TIMER_PRESCALER:      read_mux = s.prescaler;
        TIMER_DOWNCOUNTER:    read_mux = s.downcounter;
        TIMER_STATUS_CONTROL: read_mux = s.timer_sc;
        WATCHDOG_COUNTER:     read_mux = s.watchdog;
        ACCUMULATOR:          read_mux = s.accumulator;
        // Write-only and reserved locations give no data back
        default:              read_mux = UNMAPPED_READ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_s            = s;
    next_s.rvalid     = 1'b0;
    next_s.ext_valid  = 1'b0;
    next_s.ext_refuse = 1'b0;

    // Program counter wraps inside the 4K space
    case (pc_op)
      PC_STEP:   next_s.pc = pc_next_seq;
      PC_JUMP:   next_s.pc = pc_target;
      PC_CALL:   next_s.pc = pc_target;
      PC_RETURN: next_s.pc = stack_top;
      default:   next_s.pc = s.pc;
    endcase

    // Core reads take two edges so the window byte can come from memory
    case (s.rd_state)
      RD_IDLE: begin
        if (data_rd) begin
          next_s.rd_addr  = data_addr;
          next_s.win_addr = {s.win_select, data_addr[WIN_OFS_W-1:0]};
          next_s.rd_state = RD_LOOKUP;
        end
      end
      RD_LOOKUP: begin
        next_s.rdata    = read_mux;
        next_s.rvalid   = 1'b1;
        next_s.rd_state = RD_IDLE;
      end
      default: begin
        next_s.rd_state = RD_IDLE;
      end
    endcase

    // Core writes; unlisted addresses fall through untouched
    if (data_wr) begin
      if (data_addr <= RAM_LAST) begin
        next_s.ram[data_addr[WIN_OFS_W-1:0]] = data_wdata;
      end else if (data_addr > WINDOW_LAST) begin
        case (data_addr)
          INDEX_POINTER_ONE:    next_s.index_one   = data_wdata;
          INDEX_POINTER_TWO:    next_s.index_two   = data_wdata;
          SHORT_DIRECT_ONE:     next_s.short_one   = data_wdata;
          SHORT_DIRECT_TWO:     next_s.short_two   = data_wdata;
          INTERRUPT_OPTIONS:    next_s.int_options = data_wdata;
          ROM_WINDOW_SELECT: begin
            next_s.win_select = data_wdata[WIN_SEL_W-1:0] & WIN_SEL_MASK[WIN_SEL_W-1:0];
          end
          CONVERTER_CONTROL: begin
            next_s.conv_ctrl = data_wdata & ~CONV_CTRL_RO_MASK;
          end
          TIMER_PRESCALER:      next_s.prescaler   = data_wdata;
          TIMER_DOWNCOUNTER:    next_s.downcounter = data_wdata;
          TIMER_STATUS_CONTROL: next_s.timer_sc    = data_wdata;
          WATCHDOG_COUNTER:     next_s.watchdog    = data_wdata;
          ACCUMULATOR:          next_s.accumulator = data_wdata;
          default:              next_s.watchdog    = s.watchdog;
        endcase
      end
    end

    // Erase clears protection, a set option in the same cycle wins
    if (erase_all) begin
      next_s.protect = 1'b0;
    end
    if (protect_option) begin
      next_s.protect = 1'b1;
    end

    // External readout: one request in flight, refused while protected
    if (s.ext_pending) begin
      next_s.ext_pending = 1'b0;
      next_s.ext_data    = ext_rom_data;
      next_s.ext_valid   = 1'b1;
    end else if (ext_rd) begin
      if (s.protect) begin
        next_s.ext_refuse = 1'b1;
      end else begin
        next_s.ext_addr    = ext_addr;
        next_s.ext_pending = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s             <= '0;
      s.index_one   <= UNDEFINED_RESET;
      s.index_two   <= UNDEFINED_RESET;
      s.short_one   <= UNDEFINED_RESET;
      s.short_two   <= UNDEFINED_RESET;
      s.accumulator <= UNDEFINED_RESET;
      s.int_options <= UNDEFINED_RESET;
      s.conv_ctrl   <= CONV_CTRL_RESET & ~CONV_CTRL_RO_MASK;
      s.prescaler   <= PRESCALER_RESET;
      s.downcounter <= DOWNCOUNTER_RESET;
      s.timer_sc    <= TIMER_SC_RESET;
      s.watchdog    <= WATCHDOG_RESET;
      s.rd_state    <= RD_IDLE;
      s.pc          <= PC_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign data_rdata           = s.rdata;
  assign data_rvalid          = s.rvalid;
  assign program_counter      = s.pc;
  assign window_rom_addr      = s.win_addr;
  assign ext_rom_addr         = s.ext_addr;
  assign ext_rdata            = s.ext_data;
  assign ext_rvalid           = s.ext_valid;
  assign ext_refused          = s.ext_refuse;
  assign protect_active       = s.protect;
  assign converter_control    = s.conv_ctrl;
  assign timer_prescaler      = s.prescaler;
  assign timer_downcounter    = s.downcounter;
  assign timer_status_control = s.timer_sc;
  assign watchdog_counter     = s.watchdog;
  assign interrupt_options    = s.int_options;

endmodule

// [src/data_space_pkg.sv]
package data_space_pkg;

  // Widths and depths
  localparam int ADDR_W      = 8;
  localparam int DATA_W      = 8;
  localparam int PC_W        = 12;
  localparam int STACK_DEPTH = 6;
  localparam int PORT_W      = 8;
  localparam int WIN_OFS_W   = 6;
  localparam int WIN_SEL_W   = 6;
  localparam int RAM_WORDS   = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Data space map
  localparam logic [7:0] RAM_FIRST            = 8'h00;
  localparam logic [7:0] RAM_LAST             = 8'h3F;
  localparam logic [7:0] WINDOW_FIRST         = 8'h40;
  localparam logic [7:0] WINDOW_LAST          = 8'h7F;
  localparam logic [7:0] INDEX_POINTER_ONE    = 8'h80;
  localparam logic [7:0] INDEX_POINTER_TWO    = 8'h81;
  localparam logic [7:0] SHORT_DIRECT_ONE     = 8'h82;
  localparam logic [7:0] SHORT_DIRECT_TWO     = 8'h83;
  localparam logic [7:0] PORT_A_PIN_DATA      = 8'hC0;
  localparam logic [7:0] PORT_B_PIN_DATA      = 8'hC1;
  localparam logic [7:0] PORT_A_DIRECTION     = 8'hC4;
  localparam logic [7:0] PORT_B_DIRECTION     = 8'hC5;
  localparam logic [7:0] INTERRUPT_OPTIONS    = 8'hC8;
  localparam logic [7:0] ROM_WINDOW_SELECT    = 8'hC9;
  localparam logic [7:0] PORT_A_PIN_OPTIONS   = 8'hCC;
  localparam logic [7:0] PORT_B_PIN_OPTIONS   = 8'hCD;
  localparam logic [7:0] CONVERTER_RESULT     = 8'hD0;
  localparam logic [7:0] CONVERTER_CONTROL    = 8'hD1;
  localparam logic [7:0] TIMER_PRESCALER      = 8'hD2;
  localparam logic [7:0] TIMER_DOWNCOUNTER    = 8'hD3;
  localparam logic [7:0] TIMER_STATUS_CONTROL = 8'hD4;
  localparam logic [7:0] WATCHDOG_COUNTER     = 8'hD8;
  localparam logic [7:0] ACCUMULATOR          = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] PORT_RESET           = 8'h00;
  localparam logic [7:0] CONV_CTRL_RESET      = 8'h40;
  localparam logic [7:0] PRESCALER_RESET      = 8'h7F;
  localparam logic [7:0] DOWNCOUNTER_RESET    = 8'hFF;
  localparam logic [7:0] TIMER_SC_RESET       = 8'h00;
  localparam logic [7:0] WATCHDOG_RESET       = 8'hFE;
  localparam logic [7:0] UNDEFINED_RESET      = 8'h00;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;
  localparam logic [11:0] PC_RESET            = 12'h000;

  // Field layouts
  localparam logic [7:0] CONV_CTRL_RO_MASK    = 8'h40;
  localparam logic [7:0] WIN_SEL_MASK         = 8'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Program counter operations
  typedef enum logic [2:0] {
    PC_HOLD   = 3'b000,
    PC_STEP   = 3'b001,
    PC_JUMP   = 3'b010,
    PC_CALL   = 3'b011,
    PC_RETURN = 3'b100
  } pc_op_t;

  // Read sequencing
  typedef enum logic [1:0] {
    RD_IDLE   = 2'b00,
    RD_LOOKUP = 2'b01
  } rd_state_t;

endpackage

// [src/io_port_regs.sv]
module io_port_regs #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Register writes
  input  wire logic         wr_data,
  input  wire logic         wr_dir,
  input  wire logic         wr_opt,
  input  wire logic [W-1:0] wdata,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] options,
  // Read views
  output logic      [W-1:0] data_view,
  output logic      [W-1:0] dir_view
);
  import data_space_pkg::*;

  typedef struct packed {
    logic [W-1:0] data;
    logic [W-1:0] dir;
    logic [W-1:0] opt;
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] sync3;
    logic [W-1:0] level;
  } port_state_t;

  port_state_t s;
  port_state_t next_s;

  always_comb begin
    next_s       = s;
    next_s.sync1 = pin_in;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    // A pin change counts only once two stages agree
    for (int i = 0; i < W; i++) begin
      if (s.sync2[i] == s.sync3[i]) begin
        next_s.level[i] = s.sync2[i];
      end
    end
    if (wr_data) begin
      next_s.data = wdata;
    end
    if (wr_dir) begin
      next_s.dir = wdata;
    end
    if (wr_opt) begin
      next_s.opt = wdata;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pin_out   = s.data;
  assign pin_oe    = s.dir;
  assign options   = s.opt;
  // Outputs read back the latch, inputs read the filtered pin
  assign data_view = (s.data & s.dir) | (s.level & ~s.dir);
  assign dir_view  = s.dir;

endmodule

// [src/return_stack.sv]
module return_stack #(
  parameter int DEPTH = 6,
  parameter int W     = 12
) (
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Stack operations
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [W-1:0] push_value,
  output logic      [W-1:0] top
);
  import data_space_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] entry;
  } stack_state_t;

  stack_state_t s;
  stack_state_t next_s;

  // Shift stack: a seventh push drops the oldest entry, an extra pop
  // returns the last entry again, as a fixed-depth hardware stack does
  always_comb begin
    next_s = s;
    if (push) begin
      for (int i = DEPTH - 1; i > 0; i--) begin
        next_s.entry[i] = s.entry[i-1];
      end
      next_s.entry[0] = push_value;
    end else if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_s.entry[i] = s.entry[i+1];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign top = s.entry[0];

endmodule

// [verification/data_space_map_properties.sv]
module data_space_map_properties
  import data_space_pkg::*;
(
  // Clock and reset
  input wire logic         clock,
  input wire logic         rst_b,
  // Core access
  input wire logic [7:0]   data_addr,
  input wire logic         data_rd,
  input wire logic         data_wr,
  input wire logic [7:0]   data_wdata,
  input wire logic         data_rvalid,
  input wire logic [11:0]  window_rom_addr,
  input wire logic [7:0]   port_a_oe,
  // Program counter
  input wire pc_op_t       pc_op,
  input wire logic [11:0]  pc_target,
  input wire logic [11:0]  program_counter,
  // Readout and protection
  input wire logic         ext_rd,
  input wire logic [7:0]   ext_rom_data,
  input wire logic [7:0]   ext_rdata,
  input wire logic         ext_rvalid,
  input wire logic         ext_refused,
  input wire logic         protect_option,
  input wire logic         erase_all,
  input wire logic         protect_active
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  read_answer_a: assert property (data_rd |-> ##2 data_rvalid ##1 !data_rvalid)
    else $error("read answer late or stretched");
  window_offset_a: assert property (data_rd && data_addr inside {[WINDOW_FIRST:WINDOW_LAST]}
    |=> window_rom_addr[5:0] == $past(data_addr[5:0]))
    else $error("window offset not passed to memory");
  direction_write_a: assert property (data_wr && data_addr == PORT_A_DIRECTION
    |=> port_a_oe == $past(data_wdata))
    else $error("direction write lost");
  pc_call_a: assert property (pc_op == PC_CALL |=> program_counter == $past(pc_target))
    else $error("call target not loaded");
  refuse_protected_a: assert property (ext_rd && protect_active |=> ext_refused)
    else $error("protected readout not refused");
  readout_data_a: assert property (ext_rd && !protect_active
    |-> ##2 ext_rvalid && ext_rdata == $past(ext_rom_data))
    else $error("readout data wrong");
  protect_set_a: assert property (protect_option |=> protect_active)
    else $error("protection not set");
  protect_hold_a: assert property (protect_active && !erase_all |=> protect_active)
    else $error("protection dropped without erase");
  erase_clear_a: assert property (erase_all && !protect_option |=> !protect_active)
    else $error("erase did not clear protection");
  // Main scenarios
  cover property (ext_refused);
  cover property (pc_op == PC_RETURN);
  cover property (data_rvalid && data_addr == ROM_WINDOW_SELECT);
endmodule

// [verification/data_space_map_bench.sv]
module data_space_map_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import data_space_pkg::*;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
  logic clock = 0, rst_b = 0, data_rd = 0, data_wr = 0, ext_rd = 0;
  logic protect_option = 0, erase_all = 0, data_rvalid, ext_rvalid, ext_refused;
  logic protect_active;
  logic [7:0] data_addr = 0, data_wdata = 0, data_rdata, ext_rdata;
  logic [7:0] port_a_in = 0, port_b_in = 0, port_a_out, converter_control, interrupt_options;
  logic [7:0] converter_result_in = 8'h3C, converter_status_in = 8'h40;
  logic [11:0] pc_target = 0, ext_addr = 0, program_counter, window_rom_addr, ext_rom_addr;
  pc_op_t pc_op = PC_HOLD;
  int error_cnt = 0, tests_run = 0, cycles = 0;
  logic [7:0] ra [11] = '{8'hC0, 8'hC1, 8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD1, 8'hD2, 8'hD3,
    8'hD4, 8'hD8};
  logic [7:0] rv [11] = '{0, 0, 0, 0, 0, 0, 8'h40, 8'h7F, 8'hFF, 0, 8'hFE};
  logic [7:0] wa [15] = '{8'h00, 8'h3F, 8'h80, 8'h81, 8'h82, 8'h83, 8'hC4, 8'hC5, 8'hCC,
    8'hCD, 8'hD2, 8'hD3, 8'hD4, 8'hD8, 8'hFF};
  // Memory images follow fetch address bits 11 to 4, so a wrong address in those bits shows
  wire logic [7:0] window_rom_data = window_rom_addr[11:4];
  wire logic [7:0] ext_rom_data = ext_rom_addr[11:4];

  data_space_map DUT (.clock, .rst_b, .data_addr, .data_rd, .data_wr, .data_wdata,
    .data_rdata, .data_rvalid, .pc_op, .pc_target, .program_counter, .window_rom_addr,
    .window_rom_data, .ext_rd, .ext_addr, .ext_rom_addr, .ext_rom_data, .ext_rdata,
    .ext_rvalid, .ext_refused, .protect_option, .erase_all, .protect_active, .port_a_in,
    .port_a_out, .port_a_oe(), .port_a_pin_options(), .port_b_in, .port_b_out(),
    .port_b_oe(), .port_b_pin_options(), .converter_result_in, .converter_status_in,
    .converter_control, .timer_prescaler(), .timer_downcounter(), .timer_status_control(),
    .watchdog_counter(), .interrupt_options);
  ////////////////////////////////////////////////////////////////////////////
  always #20 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    {data_addr, data_wdata, data_wr} = {a, d, 1'b1};
    @(posedge clock) #1;
    data_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock) #1;
    {data_addr, data_rd} = {a, 1'b1};
    @(posedge clock) #1;
    data_rd = 0;
    // Answer stands for one cycle only, right after the lookup edge
    @(posedge clock) #1;
    `CHK(data_rvalid, 1'b1)
    `CHK(data_rdata, e)
  endtask
  task automatic xr(input logic [11:0] a, input logic ok);
    @(posedge clock) #1;
    {ext_addr, ext_rd} = {a, 1'b1};
    @(posedge clock) #1;
    ext_rd = 0;
    `CHK(ext_refused, !ok)
    @(posedge clock) #1;
    `CHK(ext_rvalid, ok)
    if (ok) `CHK(ext_rdata, a[11:4])
  endtask
  task automatic pcs(input pc_op_t op, input logic [11:0] t, input logic [11:0] e);
    @(posedge clock) #1;
    {pc_op, pc_target} = {op, t};
    @(posedge clock) #1;
    pc_op = PC_HOLD;
    `CHK(program_counter, e)
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    #1 rst_b = 1;
    repeat (2) @(posedge clock);
    foreach (ra[i]) rd(ra[i], rv[i]);
    $display("reset values done");
    foreach (wa[i]) wr(wa[i], wa[i] ^ 8'hA5);
    foreach (wa[i]) rd(wa[i], wa[i] ^ 8'hA5);
    $display("read write done");
    wr(8'hC4, 8'h0F);
    wr(8'hC0, 8'hAA);
    port_a_in = 8'h55;
    repeat (6) @(posedge clock);
    rd(8'hC0, 8'h5A);
    `CHK(port_a_out, 8'hAA)
    wr(8'hC2, 8'h55);
    rd(8'hC2, UNMAPPED_READ);
    rd(8'hC0, 8'h5A);
    wr(8'hC8, 8'h33);
    `CHK(interrupt_options, 8'h33)
    rd(8'hC8, UNMAPPED_READ);
    wr(8'hD0, 8'h11);
    rd(8'hD0, 8'h3C);
    wr(8'hD1, 8'hFF);
    `CHK(converter_control, 8'hBF)
    rd(8'hD1, 8'h40);
    $display("access kinds done");
    wr(8'hC9, 8'h2A);
    rd(8'h45, 8'hA8);
    wr(8'hC9, 8'hEA);
    wr(8'h7F, 8'h00);
    rd(8'h7F, 8'hAB);
    rd(8'hC9, UNMAPPED_READ);
    $display("window done");
    xr(12'h123, 1);
    protect_option = 1;
    @(posedge clock) #1;
    xr(12'h456, 0);
    protect_option = 0;
    repeat (3) @(posedge clock);
    #1 `CHK(protect_active, 1'b1)
    erase_all = 1;
    @(posedge clock) #1;
    erase_all = 0;
    `CHK(protect_active, 1'b0)
    xr(12'hFED, 1);
    $display("protection done");
    for (int i = 1; i <= 6; i++) pcs(PC_CALL, 12'(i * 256), 12'(i * 256));
    for (int i = 5; i >= 0; i--) pcs(PC_RETURN, 12'h000, 12'(i * 256 + 1));
    pcs(PC_JUMP, 12'hFFF, 12'hFFF);
    pcs(PC_STEP, 12'h000, 12'h000);
    $display("program counter done");
    wrap_up();
  end
endmodule

bind data_space_map data_space_map_properties chk (.clock, .rst_b, .data_addr, .data_rd,
  .data_wr, .data_wdata, .data_rvalid, .window_rom_addr, .port_a_oe, .pc_op, .pc_target,
  .program_counter, .ext_rd, .ext_rom_data, .ext_rdata, .ext_rvalid, .ext_refused,
  .protect_option, .erase_all, .protect_active);
